/* File: hdl/trace_map.svh */
`ifndef TRACE_MAP_SVH
`define TRACE_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TRACE_STATUS_ADDR   8'h0E
`define VALID_COUNT_ADDR    8'h0F
`define IRQ_STATUS_ADDR     8'h10
`define IRQ_MASK_ADDR       8'h11

// ----------------------------------------
// field positions
// ----------------------------------------
`define A_HIT_BIT           7
`define B_HIT_BIT           6
`define C_HIT_BIT           5
`define ARMED_BIT           0
`define EVT_A_BIT           0
`define EVT_B_BIT           1
`define EVT_C_BIT           2
`define EVT_FULL_BIT        3

// ----------------------------------------
// widths, reset values, limits
// ----------------------------------------
`define ADDR_W              8
`define COUNT_W             4
`define EVT_W               4
`define COUNT_MAX           4'h8
`define COUNT_ZERO          4'h0
`define COUNT_ONE           4'h1
`define STATUS_RST          8'h01
`define ARMED_RST           1'b1
`define BYTE_ZERO           8'h00
`define EVT_ZERO            4'h0

`endif

/* File: hdl/trace_pkg.sv */
package trace_pkg;

  typedef logic [7:0] reg_byte_t;
  typedef logic [3:0] word_count_t;

  // kind of reset seen this cycle
  typedef enum logic [1:0] {
    RST_NONE    = 2'h0,
    RST_FULL    = 2'h1,
    RST_END_RUN = 2'h3
  } reset_kind_t;

endpackage

/* File: hdl/sat_word_counter.sv */
`timescale 1ns/100ps
`default_nettype none
`include "trace_map.svh"

module sat_word_counter #(
  parameter int                        WIDTH = `COUNT_W,
  parameter logic [`COUNT_W-1:0]       MAX   = `COUNT_MAX
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  input  wire logic                    zero,
  input  wire logic                    hold,
  input  wire logic                    restart,
  input  wire logic                    inc,
  output logic      [WIDTH-1:0]        count
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  wire              below_max = count_q < WIDTH'(MAX);
  wire  [WIDTH-1:0] first_val = inc ? WIDTH'(`COUNT_ONE) : '0;

  // a capture in the arming cycle is the first word of the run
  assign count_d = zero    ? '0 :
                   hold    ? count_q :
                   restart ? first_val :
                   (inc && below_max) ? count_q + WIDTH'(1) : count_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count = count_q;

endmodule
`default_nettype wire

/* File: hdl/trace_status_and_count.sv */
`timescale 1ns/100ps
`default_nettype none
`include "trace_map.svh"

module trace_status_and_count (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  input  wire logic                    chip_reset,
  input  wire logic                    trace_unit_enable,
  input  wire logic                    arm_ctl,
  input  wire logic                    begin_trigger,
  input  wire logic                    match_a,
  input  wire logic                    match_b,
  input  wire logic                    match_c,
  input  wire logic                    fifo_capture,
  input  wire logic                    fifo_read,
  input  wire logic [`ADDR_W-1:0]      addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output trace_pkg::reg_byte_t         rdata,
  output trace_pkg::reg_byte_t         trace_status,
  output trace_pkg::reg_byte_t         fifo_valid_word_count,
  output logic                         irq
);

  // ----------------------------------------
  // reset classification
  // ----------------------------------------
  trace_pkg::reset_kind_t rst_kind;
  logic                   end_run_w;

  // begin-trigger low with the unit enabled marks an end-type run
  assign end_run_w = trace_unit_enable && !begin_trigger;

  assign rst_kind = !chip_reset ? trace_pkg::RST_NONE :
                    end_run_w   ? trace_pkg::RST_END_RUN :
                                  trace_pkg::RST_FULL;

  wire full_rst_w    = (rst_kind == trace_pkg::RST_FULL);
  wire end_run_rst_w = (rst_kind == trace_pkg::RST_END_RUN);

  // ----------------------------------------
  // arming
  // ----------------------------------------
  logic arm_prev_q;
  wire  armed_w    = trace_unit_enable && arm_ctl;
  wire  arm_rise_w = armed_w && !arm_prev_q && !chip_reset;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      arm_prev_q <= 1'b0;
    end else begin
      arm_prev_q <= armed_w && !chip_reset;
    end
  end

  // ----------------------------------------
  // comparator hit flags
  // ----------------------------------------
  logic [2:0] hit_q;
  logic [2:0] hit_d;
  wire  [2:0] match_w = {match_a, match_b, match_c};

  // a hit in the arming cycle survives the clear
  assign hit_d = rst_kind == trace_pkg::RST_FULL    ? 3'h0 :
                 rst_kind == trace_pkg::RST_END_RUN ? hit_q :
                 arm_rise_w ? (match_w & {3{armed_w}}) :
                 hit_q | (match_w & {3{armed_w}});

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hit_q <= 3'h0;
    end else begin
      hit_q <= hit_d;
    end
  end

  wire comparator_a_hit_flag = hit_q[2];
  wire comparator_b_hit_flag = hit_q[1];
  wire comparator_c_hit_flag = hit_q[0];

  // ----------------------------------------
  // arm mirror
  // ----------------------------------------
  logic armed_mirror_flag_q;
  logic armed_mirror_flag_d;

  // with the unit disabled and no chip reset the flag keeps its last value
  always_comb begin
    unique case (rst_kind)
      trace_pkg::RST_FULL:    armed_mirror_flag_d = 1'b1;
      trace_pkg::RST_END_RUN: armed_mirror_flag_d = 1'b0;
      trace_pkg::RST_NONE:
        armed_mirror_flag_d = trace_unit_enable ? arm_ctl
                                                : armed_mirror_flag_q;
      default:                armed_mirror_flag_d = armed_mirror_flag_q;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_mirror_flag_q <= `ARMED_RST;
    end else begin
      armed_mirror_flag_q <= armed_mirror_flag_d;
    end
  end

  // ----------------------------------------
  // valid word count
  // ----------------------------------------
  trace_pkg::word_count_t valid_word_count;
  wire capture_w = fifo_capture && armed_w && !chip_reset;

  // fifo_read is deliberately not an input of the counter
  sat_word_counter #(
    .WIDTH   (`COUNT_W),
    .MAX     (`COUNT_MAX)
  ) u_count (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .zero    (full_rst_w),
    .hold    (end_run_rst_w),
    .restart (arm_rise_w),
    .inc     (capture_w),
    .count   (valid_word_count)
  );

  wire full_evt_w = capture_w && !arm_rise_w &&
                    (valid_word_count == `COUNT_MAX - `COUNT_ONE);

  // ----------------------------------------
  // register images
  // ----------------------------------------
  trace_pkg::reg_byte_t status_img;
  trace_pkg::reg_byte_t count_img;

  always_comb begin
    status_img             = `BYTE_ZERO;
    status_img[`A_HIT_BIT] = comparator_a_hit_flag;
    status_img[`B_HIT_BIT] = comparator_b_hit_flag;
    status_img[`C_HIT_BIT] = comparator_c_hit_flag;
    status_img[`ARMED_BIT] = armed_mirror_flag_q;
    count_img              = {4'h0, valid_word_count};
  end

  assign trace_status          = status_img;
  assign fifo_valid_word_count = count_img;

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  logic [`EVT_W-1:0] irq_status_q;
  logic [`EVT_W-1:0] irq_status_d;
  logic [`EVT_W-1:0] irq_mask_q;
  logic [`EVT_W-1:0] evt_w;

  function automatic logic hit(input logic [`ADDR_W-1:0] a,
                               input logic [`ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  wire wr_irq_status = wr && hit(addr, `IRQ_STATUS_ADDR);
  wire wr_irq_mask   = wr && hit(addr, `IRQ_MASK_ADDR);

  always_comb begin
    evt_w                = `EVT_ZERO;
    evt_w[`EVT_A_BIT]    = match_a && armed_w && !chip_reset;
    evt_w[`EVT_B_BIT]    = match_b && armed_w && !chip_reset;
    evt_w[`EVT_C_BIT]    = match_c && armed_w && !chip_reset;
    evt_w[`EVT_FULL_BIT] = full_evt_w;
  end

  // write-one-to-clear; a new event in the same cycle wins
  wire [`EVT_W-1:0] w1c_w = wr_irq_status ? wdata[`EVT_W-1:0] : `EVT_ZERO;
  assign irq_status_d = (irq_status_q & ~w1c_w) | evt_w;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status_q <= `EVT_ZERO;
      irq_mask_q   <= `EVT_ZERO;
    end else begin
      irq_status_q <= irq_status_d;
      if (wr_irq_mask) begin
        irq_mask_q <= wdata[`EVT_W-1:0];
      end
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  trace_pkg::reg_byte_t rd_mux;
  trace_pkg::reg_byte_t rdata_q;

  // writes to the two trace registers fall through on purpose
  assign rd_mux =
    hit(addr, `TRACE_STATUS_ADDR) ? status_img :
    hit(addr, `VALID_COUNT_ADDR)  ? count_img :
    hit(addr, `IRQ_STATUS_ADDR)   ? {4'h0, irq_status_q} :
    hit(addr, `IRQ_MASK_ADDR)     ? {4'h0, irq_mask_q} :
                                    `BYTE_ZERO;

  // data stand for exactly one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= `BYTE_ZERO;
    end else begin
      rdata_q <= rd ? rd_mux : `BYTE_ZERO;
    end
  end

  assign rdata = rdata_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence arming_s;
    arm_rise_w;
  endsequence

  sequence quiet_s;
    !chip_reset && !arm_rise_w;
  endsequence

  sequence full_count_s;
    (valid_word_count == `COUNT_MAX) and quiet_s;
  endsequence

  a_hit_a_set: assert property (
    match_a && armed_w && !chip_reset |=> comparator_a_hit_flag)
    else $error("comparator a hit not recorded");

  a_hit_b_set: assert property (
    match_b && armed_w && !chip_reset |=> comparator_b_hit_flag)
    else $error("comparator b hit not recorded");

  a_hit_c_hold: assert property (
    comparator_c_hit_flag ##0 quiet_s |=> comparator_c_hit_flag)
    else $error("comparator c flag dropped");

  a_hit_arm_clear: assert property (
    arming_s ##0 (match_w == 3'h0) |=> hit_q == 3'h0)
    else $error("arming did not clear hit flags");

  a_arm_mirror: assert property (
    trace_unit_enable && !chip_reset
      |=> armed_mirror_flag_q == $past(arm_ctl))
    else $error("arm flag does not mirror arm control");

  a_end_run_keep: assert property (
    end_run_rst_w |=> !armed_mirror_flag_q && hit_q == $past(hit_q))
    else $error("end-run reset changed hit flags");

  a_full_rst_vals: assert property (
    full_rst_w |=> status_img == `STATUS_RST
                   && valid_word_count == `COUNT_ZERO)
    else $error("full reset values wrong");

  a_count_range: assert property (
    valid_word_count <= `COUNT_MAX)
    else $error("count beyond eight");

  a_count_step: assert property (
    (capture_w && valid_word_count < `COUNT_MAX) ##0 quiet_s
      |=> valid_word_count == $past(valid_word_count) + `COUNT_ONE)
    else $error("capture did not add one");

  a_arm_restart: assert property (
    arming_s ##0 !capture_w |=> valid_word_count == `COUNT_ZERO)
    else $error("arming did not clear count");

  a_count_sat: assert property (
    full_count_s ##1 full_count_s ##1 quiet_s
      |=> valid_word_count == `COUNT_MAX)
    else $error("count left eight");

  a_read_no_dec: assert property (
    (fifo_read && !capture_w) ##0 quiet_s
      |=> valid_word_count == $past(valid_word_count))
    else $error("fifo read changed count");

  a_end_run_count: assert property (
    end_run_rst_w
      |=> valid_word_count == $past(valid_word_count))
    else $error("end-run reset changed count");

  a_read_zeros: assert property (
    rd && hit(addr, `VALID_COUNT_ADDR) |=> rdata[7:4] == 4'h0)
    else $error("count upper bits not zero");

  a_read_timing: assert property (
    rd && hit(addr, `TRACE_STATUS_ADDR) |=> rdata == $past(status_img)
      ##1 ($past(rd) || rdata == `BYTE_ZERO))
    else $error("status read data wrong or held");

  a_irq_level: assert property (
    (irq_status_q & irq_mask_q) != `EVT_ZERO |-> irq)
    else $error("irq low with unmasked event");

  a_irq_set_wins: assert property (
    match_a && armed_w && !chip_reset && wr_irq_status
      |=> irq_status_q[`EVT_A_BIT])
    else $error("clear beat a new event");

endmodule
`default_nettype wire

/* File: test/trace_source.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// comparator and capture side model
// ----------------------------------------
// a go pulse loads a burst length; one pulse of the chosen kind then
// follows on each edge, back to back, so the unit sees no idle gaps
module trace_source (
  input  wire logic       sys_clk,
  input  wire logic       go,
  input  wire logic [2:0] kind,
  input  wire logic [3:0] n,
  output logic            match_a,
  output logic            match_b,
  output logic            match_c,
  output logic            fifo_capture,
  output logic            fifo_read,
  output logic            busy
);
  logic [3:0] left_q = 4'h0;

  always @(posedge sys_clk) begin
    if (go) begin
      left_q <= n;
    end else if (left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
    end
  end

  assign busy         = (left_q != 4'h0);
  assign match_a      = busy && (kind == 3'h0);
  assign match_b      = busy && (kind == 3'h1);
  assign match_c      = busy && (kind == 3'h2);
  assign fifo_capture = busy && (kind == 3'h3);
  // read-out length is the burst length n given with the go pulse
  assign fifo_read    = busy && (kind == 3'h4);
endmodule
`default_nettype wire

/* File: test/trace_status_and_count_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module trace_status_and_count_tb;
  logic                 sys_clk = 1'b0;
  logic                 rst_b = 1'b0;
  logic                 chip_reset = 1'b0;
  logic                 trace_unit_enable = 1'b0;
  logic                 arm_ctl = 1'b0;
  logic                 begin_trigger = 1'b0;
  logic                 match_a, match_b, match_c;
  logic                 fifo_capture, fifo_read, busy;
  logic [7:0]           addr = 8'h00;
  logic [7:0]           wdata = 8'h00;
  logic                 wr = 1'b0;
  logic                 rd = 1'b0;
  logic                 go = 1'b0;
  logic [2:0]           kind = 3'h0;
  logic [3:0]           n = 4'h0;
  trace_pkg::reg_byte_t rdata, trace_status, fifo_valid_word_count;
  logic                 irq;
  int                   errors = 0;
  int                   comparisons = 0;

  always #20 sys_clk = ~sys_clk;

  trace_status_and_count i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .chip_reset(chip_reset),
    .trace_unit_enable(trace_unit_enable), .arm_ctl(arm_ctl),
    .begin_trigger(begin_trigger), .match_a(match_a),
    .match_b(match_b), .match_c(match_c),
    .fifo_capture(fifo_capture), .fifo_read(fifo_read),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .trace_status(trace_status),
    .fifo_valid_word_count(fifo_valid_word_count), .irq(irq)
  );

  trace_source i_src (
    .sys_clk(sys_clk), .go(go), .kind(kind), .n(n),
    .match_a(match_a), .match_b(match_b), .match_c(match_c),
    .fifo_capture(fifo_capture), .fifo_read(fifo_read), .busy(busy)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    check($sformatf("reg %h", a), rdata, exp);
  endtask

  task automatic burst(input logic [2:0] k, input logic [3:0] len);
    @(posedge sys_clk);
    kind <= k;
    n <= len;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (len) @(posedge sys_clk);
    #1;
  endtask

  task automatic arm;
    @(posedge sys_clk);
    arm_ctl <= 1'b0;
    @(posedge sys_clk);
    arm_ctl <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask

  // the control register drops arm with any chip reset
  task automatic chip_pulse(input logic beg, input logic [7:0] exp_s,
                            input logic [7:0] exp_c);
    @(posedge sys_clk);
    begin_trigger <= beg;
    chip_reset <= 1'b1;
    arm_ctl <= 1'b0;
    @(posedge sys_clk);
    chip_reset <= 1'b0;
    #1;
    check("trace_status", trace_status, exp_s);
    check("count port", fifo_valid_word_count, exp_c);
    @(posedge sys_clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd_chk(8'h0E, 8'h01);
    rd_chk(8'h0F, 8'h00);
    check("irq", {7'h00, irq}, 8'h00);
    @(posedge sys_clk);
    trace_unit_enable <= 1'b1;
  endtask

  task automatic t_hits;
    burst(3'h2, 4'h2);
    rd_chk(8'h0E, 8'h00);
    arm();
    rd_chk(8'h0E, 8'h01);
    burst(3'h0, 4'h1);
    rd_chk(8'h0E, 8'h81);
    burst(3'h1, 4'h3);
    rd_chk(8'h0E, 8'hC1);
    burst(3'h2, 4'h1);
    rd_chk(8'h0E, 8'hE1);
    @(posedge sys_clk);
    arm_ctl <= 1'b0;
    rd_chk(8'h0E, 8'hE0);
  endtask

  task automatic t_count;
    arm();
    rd_chk(8'h0E, 8'h01);
    rd_chk(8'h0F, 8'h00);
    burst(3'h3, 4'h7);
    rd_chk(8'h0F, 8'h07);
    burst(3'h3, 4'h3);
    rd_chk(8'h0F, 8'h08);
    burst(3'h4, 4'h8);
    rd_chk(8'h0F, 8'h08);
  endtask

  // irq status: A, B, C hits and count reaching eight
  task automatic t_irq;
    rd_chk(8'h10, 8'h0F);
    wr_reg(8'h11, 8'h08);
    rd_chk(8'h11, 8'h08);
    check("irq", {7'h00, irq}, 8'h01);
    wr_reg(8'h10, 8'h08);
    rd_chk(8'h10, 8'h07);
    check("irq", {7'h00, irq}, 8'h00);
    wr_reg(8'h11, 8'h01);
    check("irq", {7'h00, irq}, 8'h01);
    wr_reg(8'h10, 8'h07);
    check("irq", {7'h00, irq}, 8'h00);
  endtask

  task automatic t_ro;
    wr_reg(8'h0E, 8'hFF);
    wr_reg(8'h0F, 8'hFF);
    rd_chk(8'h0E, 8'h01);
    rd_chk(8'h0F, 8'h08);
    rd_chk(8'h20, 8'h00);
  endtask

  task automatic t_chip;
    burst(3'h0, 4'h1);
    rd_chk(8'h0E, 8'h81);
    check("irq", {7'h00, irq}, 8'h01);
    chip_pulse(1'b0, 8'h80, 8'h08);
    rd_chk(8'h0E, 8'h80);
    rd_chk(8'h0F, 8'h08);
    arm();
    rd_chk(8'h0F, 8'h00);
    burst(3'h3, 4'h2);
    rd_chk(8'h0F, 8'h02);
    chip_pulse(1'b1, 8'h01, 8'h00);
    rd_chk(8'h0E, 8'h00);
    rd_chk(8'h0F, 8'h00);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_hits();
    t_count();
    t_irq();
    t_ro();
    t_chip();
    close_out();
  end

  // the whole sequence needs about 135 cycles
  initial begin
    #200000;
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
